// *** src/pcs_pkg.sv ***
package pcs_pkg;
	// widths and depths
	localparam int PC_W = 15;
	localparam int STK_DEPTH = 16;
	localparam int SP_W = 5;
	localparam int ADDR_W = 13;
	localparam int CALL_OPND_W = 11;
	localparam int BRA_OPND_W = 9;
	// core register offsets inside every bank
	localparam logic [6:0] OFF_INDIRECT_DATA_PORT_0 = 7'h00;
	localparam logic [6:0] OFF_INDIRECT_DATA_PORT_1 = 7'h01;
	localparam logic [6:0] OFF_PCL = 7'h02;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_PTR0_LO = 7'h04;
	localparam logic [6:0] OFF_PTR0_HI = 7'h05;
	localparam logic [6:0] OFF_PTR1_LO = 7'h06;
	localparam logic [6:0] OFF_PTR1_HI = 7'h07;
	localparam logic [6:0] OFF_BANK = 7'h08;
	localparam logic [6:0] OFF_WACC = 7'h09;
	localparam logic [6:0] OFF_LATCH = 7'h0A;
	localparam logic [6:0] OFF_INTCTL = 7'h0B;
	localparam logic [6:0] CORE_COUNT = 7'h0C;
	// region boundaries of a bank
	localparam logic [6:0] SFR_END_LOW = 7'h20;
	localparam logic [6:0] COMMON_START = 7'h70;
	localparam logic [5:0] HIGH_BANK_FIRST = 6'h3C;
	// stack access registers, full data addresses
	localparam logic [12:0] ADR_STACK_POINTER_REG = 13'h0FED;
	localparam logic [12:0] ADR_STACK_TOP_LOW = 13'h0FEE;
	localparam logic [12:0] ADR_STACK_TOP_HIGH = 13'h0FEF;
	// status bit positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	// reset values and pointer states
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam logic [14:0] PC_ONE = 15'h0001;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [4:0] SP_EMPTY = 5'h1F;
	localparam logic [4:0] SP_FULL = 5'h0F;
	localparam logic [4:0] SP_FIRST = 5'h00;
	localparam logic [3:0] IDX_ONE = 4'h1;

	typedef enum logic [2:0] {pcs_op_hold, pcs_op_inc, pcs_op_call, pcs_op_register_computed_call,
		pcs_op_brw, pcs_op_bra, pcs_op_irq, pcs_op_ret} pcs_op_t;
	typedef enum logic [2:0] {pcs_reg_core, pcs_reg_sfr, pcs_reg_gpr, pcs_reg_common,
		pcs_reg_stack} pcs_region_t;
	typedef struct packed {logic wr; logic rd; logic [12:0] addr; logic [7:0] wdata;} pcs_bus_t;
	typedef struct packed {pcs_op_t op; logic [10:0] operand;} pcs_cmd_t;
	typedef struct packed {logic upd_z; logic upd_dc; logic upd_c; logic sub;
		logic z; logic dc; logic c;} pcs_alu_t;
	typedef struct packed {logic load; logic to; logic pd;} pcs_hw_t;
endpackage : pcs_pkg

// *** src/pcs_core.sv ***
module pcs_core
	import pcs_pkg::*;
#(
	parameter logic [14:0] IRQ_VECTOR = 15'h0004
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire pcs_bus_t bus,
	input wire pcs_cmd_t cmd,
	input wire pcs_alu_t alu,
	input wire pcs_hw_t hw,
	input wire logic stack_fault_reset_enable,
	input wire logic overflow_clear,
	input wire logic underflow_clear,
	output logic [14:0] pc,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output pcs_region_t rd_region,
	output logic [7:0] working_accumulator,
	output logic [5:0] bank_selector,
	output logic [15:0] pointer_0,
	output logic [15:0] pointer_1,
	output logic [7:0] interrupt_control,
	output logic [7:0] status,
	output logic [4:0] stack_pointer,
	output logic stack_overflow_flag,
	output logic stack_underflow_flag,
	output logic stack_fault_reset
);

////////////////////////////////////////////////////////////////////////////////

	logic rst_meta;
	logic rst_sync;
	logic [6:0] program_counter_latch;
	logic [14:0] stack_mem [STK_DEPTH];
	logic [14:0] next_pc;
	logic [14:0] pc_plus1;
	logic [14:0] tos_value;
	logic [4:0] next_sp;
	logic [7:0] read_value;
	logic push;
	logic pop;
	logic ovf;
	logic unf;
	logic fault_now;
	logic flags_owned;
	logic status_wr_ok;

	// core window hit: bank bits ignored so every bank and alias agrees
	function automatic logic core_hit(input logic [12:0] a, input logic [6:0] off);
		core_hit = (a[6:0] == off);
	endfunction : core_hit

	// region of a data address, stack registers checked before the bank layout
	function automatic pcs_region_t region_of(input logic [12:0] a);
		if (a == ADR_STACK_POINTER_REG || a == ADR_STACK_TOP_LOW || a == ADR_STACK_TOP_HIGH)
			region_of = pcs_reg_stack;
		else if (a[6:0] < CORE_COUNT)
			region_of = pcs_reg_core;
		else if (a[6:0] >= COMMON_START)
			region_of = pcs_reg_common;
		else if (a[12:7] >= HIGH_BANK_FIRST || a[6:0] < SFR_END_LOW)
			region_of = pcs_reg_sfr;
		else
			region_of = pcs_reg_gpr;
	endfunction : region_of

////////////////////////////////////////////////////////////////////////////////

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// stack actions requested by the execute unit
	always_comb
	begin
		push = (cmd.op == pcs_op_call) || (cmd.op == pcs_op_register_computed_call) || (cmd.op == pcs_op_irq);
		pop = (cmd.op == pcs_op_ret);
		ovf = push && (stack_pointer == SP_FULL);
		unf = pop && (stack_pointer == SP_EMPTY);
		fault_now = stack_fault_reset_enable && (ovf || unf);
		tos_value = stack_mem[stack_pointer[3:0]];
		pc_plus1 = pc + PC_ONE;
	end

	// pointer steps; the low four bits wrap, which gives the circular behaviour
	always_comb
	begin
		next_sp = stack_pointer;
		if (push)
			next_sp = (stack_pointer == SP_EMPTY) ? SP_FIRST : {1'b0, stack_pointer[3:0] + IDX_ONE};
		else if (pop)
			next_sp = (stack_pointer == SP_FIRST) ? SP_EMPTY : {1'b0, stack_pointer[3:0] - IDX_ONE};
		else if (bus.wr && bus.addr == ADR_STACK_POINTER_REG)
			next_sp = bus.wdata[4:0];
	end

	// five-bit pointer; a fault acts as a reset and empties it
	always_ff @(posedge clock or negedge rst_sync)
	begin
		if (!rst_sync)
			stack_pointer <= SP_EMPTY;
		else if (fault_now)
			stack_pointer <= SP_EMPTY;
		else
			stack_pointer <= next_sp;
	end

	// entry storage; a push wins over a software top-of-stack write in the same cycle
	always_ff @(posedge clock)
	begin
		if (push && !fault_now)
			stack_mem[next_sp[3:0]] <= (cmd.op == pcs_op_irq) ? pc : pc_plus1;
		else if (bus.wr && bus.addr == ADR_STACK_TOP_LOW)
			stack_mem[stack_pointer[3:0]][7:0] <= bus.wdata;
		else if (bus.wr && bus.addr == ADR_STACK_TOP_HIGH)
			stack_mem[stack_pointer[3:0]][14:8] <= bus.wdata[6:0];
	end

	// sticky overflow and underflow flags, a new event beats a clear in the same cycle; the fault reset output is a one-cycle pulse
	always_ff @(posedge clock or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			stack_overflow_flag <= 1'b0;
			stack_underflow_flag <= 1'b0;
			stack_fault_reset <= 1'b0;
		end
		else
		begin
			if (ovf)
				stack_overflow_flag <= 1'b1;
			else if (overflow_clear)
				stack_overflow_flag <= 1'b0;
			if (unf)
				stack_underflow_flag <= 1'b1;
			else if (underflow_clear)
				stack_underflow_flag <= 1'b0;
			stack_fault_reset <= fault_now;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// program counter source select; a low-byte write outranks the sequencing op
	always_comb
	begin
		next_pc = pc;
		if (bus.wr && core_hit(bus.addr, OFF_PCL))
			next_pc = {program_counter_latch, bus.wdata};
		else
			case (cmd.op)
				pcs_op_inc: next_pc = pc_plus1;
				pcs_op_call: next_pc = {program_counter_latch[6:3], cmd.operand};
				pcs_op_register_computed_call: next_pc = {program_counter_latch, working_accumulator};
				pcs_op_brw: next_pc = pc_plus1 + {7'h00, working_accumulator};
				pcs_op_bra: next_pc = pc_plus1 + {{6{cmd.operand[8]}}, cmd.operand[8:0]};
				pcs_op_irq: next_pc = IRQ_VECTOR;
				pcs_op_ret: next_pc = tos_value;
				default: next_pc = pc;
			endcase
	end

	// counter register; upper bits have no write path of their own
	always_ff @(posedge clock or negedge rst_sync)
	begin
		if (!rst_sync)
			pc <= PC_RESET;
		else if (fault_now)
			pc <= PC_RESET;
		else
			pc <= next_pc;
	end

////////////////////////////////////////////////////////////////////////////////

	// plain core storage; the latch only moves on its own bus write
	always_ff @(posedge clock or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			program_counter_latch <= 7'h00;
			working_accumulator <= BYTE_ZERO;
			bank_selector <= 6'h00;
			pointer_0 <= 16'h0000;
			pointer_1 <= 16'h0000;
			interrupt_control <= BYTE_ZERO;
		end
		else if (bus.wr)
		begin
			if (core_hit(bus.addr, OFF_LATCH))
				program_counter_latch <= bus.wdata[6:0];
			if (core_hit(bus.addr, OFF_WACC))
				working_accumulator <= bus.wdata;
			if (core_hit(bus.addr, OFF_BANK))
				bank_selector <= bus.wdata[5:0];
			if (core_hit(bus.addr, OFF_PTR0_LO))
				pointer_0[7:0] <= bus.wdata;
			if (core_hit(bus.addr, OFF_PTR0_HI))
				pointer_0[15:8] <= bus.wdata;
			if (core_hit(bus.addr, OFF_PTR1_LO))
				pointer_1[7:0] <= bus.wdata;
			if (core_hit(bus.addr, OFF_PTR1_HI))
				pointer_1[15:8] <= bus.wdata;
			if (core_hit(bus.addr, OFF_INTCTL))
				interrupt_control <= bus.wdata;
		end
	end

	// any flag the instruction owns blocks all three arithmetic bits from the write
	always_comb
	begin
		flags_owned = alu.upd_z || alu.upd_dc || alu.upd_c;
		status_wr_ok = bus.wr && core_hit(bus.addr, OFF_STATUS) && !flags_owned;
	end

	// status bits; in subtraction the alu reports raw borrows, inverted here
	always_ff @(posedge clock or negedge rst_sync)
	begin
		if (!rst_sync)
			status <= STATUS_RESET;
		else
		begin
			if (hw.load)
			begin
				status[ST_TO] <= hw.to;
				status[ST_PD] <= hw.pd;
			end
			if (alu.upd_z)
				status[ST_Z] <= alu.z;
			else if (status_wr_ok)
				status[ST_Z] <= bus.wdata[ST_Z];
			if (alu.upd_dc)
				status[ST_DC] <= alu.sub ? !alu.dc : alu.dc;
			else if (status_wr_ok)
				status[ST_DC] <= bus.wdata[ST_DC];
			if (alu.upd_c)
				status[ST_C] <= alu.sub ? !alu.c : alu.c;
			else if (status_wr_ok)
				status[ST_C] <= bus.wdata[ST_C];
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// read mux; indirect ports and non-core regions other than the stack registers read zero, outside logic supplies them
	always_comb
	begin
		read_value = BYTE_ZERO;
		if (bus.addr == ADR_STACK_POINTER_REG)
			read_value = {3'b000, stack_pointer};
		else if (bus.addr == ADR_STACK_TOP_LOW)
			read_value = tos_value[7:0];
		else if (bus.addr == ADR_STACK_TOP_HIGH)
			read_value = {1'b0, tos_value[14:8]};
		else if (region_of(bus.addr) != pcs_reg_core)
			read_value = BYTE_ZERO;
		else if (core_hit(bus.addr, OFF_PCL))
			read_value = pc[7:0];
		else if (core_hit(bus.addr, OFF_STATUS))
			read_value = status;
		else if (core_hit(bus.addr, OFF_PTR0_LO))
			read_value = pointer_0[7:0];
		else if (core_hit(bus.addr, OFF_PTR0_HI))
			read_value = pointer_0[15:8];
		else if (core_hit(bus.addr, OFF_PTR1_LO))
			read_value = pointer_1[7:0];
		else if (core_hit(bus.addr, OFF_PTR1_HI))
			read_value = pointer_1[15:8];
		else if (core_hit(bus.addr, OFF_BANK))
			read_value = {2'b00, bank_selector};
		else if (core_hit(bus.addr, OFF_WACC))
			read_value = working_accumulator;
		else if (core_hit(bus.addr, OFF_LATCH))
			read_value = {1'b0, program_counter_latch};
		else if (core_hit(bus.addr, OFF_INTCTL))
			read_value = interrupt_control;
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge clock or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			rd_data <= BYTE_ZERO;
			rd_valid <= 1'b0;
			rd_region <= pcs_reg_core;
		end
		else
		begin
			rd_valid <= bus.rd;
			if (bus.rd)
			begin
				rd_data <= read_value;
				rd_region <= region_of(bus.addr);
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// checks kept beside the logic
	logic pcl_wr;
	assign pcl_wr = bus.wr && core_hit(bus.addr, OFF_PCL);

	pcl_load_a: assert property (@(posedge clock) disable iff (!rst_sync)
		pcl_wr && !fault_now |=> pc == {$past(program_counter_latch), $past(bus.wdata)})
		else $error("low byte write did not load all counter bits");
	call_target_a: assert property (@(posedge clock) disable iff (!rst_sync)
		cmd.op == pcs_op_call && !pcl_wr && !fault_now
		|=> pc == {$past(program_counter_latch[6:3]), $past(cmd.operand)})
		else $error("call target wrong");
	register_computed_call_target_a: assert property (@(posedge clock) disable iff (!rst_sync)
		cmd.op == pcs_op_register_computed_call && !pcl_wr && !fault_now
		|=> pc[7:0] == $past(working_accumulator) && pc[14:8] == $past(program_counter_latch))
		else $error("computed call target wrong");
	brw_target_a: assert property (@(posedge clock) disable iff (!rst_sync)
		cmd.op == pcs_op_brw && !pcl_wr |=> pc == 15'($past(pc) + PC_ONE + $past(working_accumulator)))
		else $error("register branch target wrong");
	bra_target_a: assert property (@(posedge clock) disable iff (!rst_sync)
		cmd.op == pcs_op_bra && !pcl_wr
		|=> pc == 15'($past(pc) + PC_ONE + {{6{$past(cmd.operand[8])}}, $past(cmd.operand[8:0])}))
		else $error("immediate branch target wrong");
	tp_protect_a: assert property (@(posedge clock) disable iff (!rst_sync)
		!hw.load |=> $stable(status[ST_TO:ST_PD]))
		else $error("time-out or power-down flag moved without hardware load");
	flag_protect_a: assert property (@(posedge clock) disable iff (!rst_sync)
		bus.wr && core_hit(bus.addr, OFF_STATUS) && alu.upd_z && !alu.upd_c
		|=> status[ST_Z] == $past(alu.z) && status[ST_C] == $past(status[ST_C]))
		else $error("status write overrode owned flags");
	borrow_invert_a: assert property (@(posedge clock) disable iff (!rst_sync)
		alu.upd_c && alu.sub |=> status[ST_C] == !$past(alu.c))
		else $error("carry not an inverted borrow");
	push_order_a: assert property (@(posedge clock) disable iff (!rst_sync)
		cmd.op == pcs_op_call && stack_pointer < SP_FULL
		|=> stack_pointer == $past(stack_pointer) + 5'h01 ##0 tos_value == 15'($past(pc) + PC_ONE))
		else $error("push did not step then store");
	pop_order_a: assert property (@(posedge clock) disable iff (!rst_sync)
		pop && !fault_now && !pcl_wr && stack_pointer != SP_FIRST
		|=> pc == $past(tos_value) && stack_pointer == {1'b0, $past(stack_pointer[3:0]) - IDX_ONE})
		else $error("return did not read then decrement");
	wrap_push_a: assert property (@(posedge clock) disable iff (!rst_sync)
		ovf && !stack_fault_reset_enable |=> stack_pointer == SP_FIRST && stack_overflow_flag)
		else $error("circular push did not wrap");
	fault_reset_a: assert property (@(posedge clock) disable iff (!rst_sync)
		(ovf || unf) && stack_fault_reset_enable
		|=> stack_fault_reset && pc == PC_RESET && stack_pointer == SP_EMPTY)
		else $error("stack fault did not reset");
	latch_keep_a: assert property (@(posedge clock) disable iff (!rst_sync)
		(push || pop) && !(bus.wr && core_hit(bus.addr, OFF_LATCH)) |=> $stable(program_counter_latch))
		else $error("stack action changed the latch");
	underflow_flag_a: assert property (@(posedge clock) disable iff (!rst_sync)
		unf |=> stack_underflow_flag [*2] or (stack_underflow_flag ##1 1'b1))
		else $error("underflow flag not set");

endmodule : pcs_core

// *** tb/pcs_exec_model.sv ***
module pcs_exec_model
	import pcs_pkg::*;
(
	input wire logic clock,
	output pcs_cmd_t cmd,
	output pcs_alu_t alu
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// idle until the bench asks for an instruction
	initial
	begin
		cmd = '{pcs_op_hold, 11'h7FF};
		alu = '0;
	end

	// one instruction, entered at a falling edge; afterwards the operand is
	// inverted so a stale operand can never look valid, and one idle cycle
	// follows so back-to-back calls never rewrite a field in one time step
	task automatic step(input pcs_op_t op, input logic [10:0] opnd, input pcs_alu_t flags);
		cmd.op = op;
		cmd.operand = opnd;
		alu = flags;
		@(negedge clock);
		cmd.op = pcs_op_hold;
		cmd.operand = ~opnd;
		alu = '0;
		@(negedge clock);
	endtask : step
endmodule : pcs_exec_model

// *** tb/pcs_core_tb.sv ***
module pcs_core_tb
	import pcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0;
	logic rstn = 1'b0;
	pcs_bus_t bus = '0;
	pcs_cmd_t cmd;
	pcs_alu_t alu;
	pcs_hw_t hw = '0;
	logic fault_en = 1'b0;
	logic ovf_clr = 1'b0;
	logic unf_clr = 1'b0;
	logic [14:0] pc;
	logic [7:0] rd_data;
	logic rd_valid;
	pcs_region_t rd_region;
	logic [7:0] status;
	logic [7:0] wacc;
	logic [5:0] bsel;
	logic [15:0] ptr0;
	logic [15:0] ptr1;
	logic [7:0] intctl;
	logic [4:0] sp;
	logic ovf;
	logic unf;
	logic fault;
	int fails = 0;
	int tests_run = 0;
	logic [5:0] banks [4] = '{6'h00, 6'h01, 6'h21, 6'h3F};

	////////////////////////////////////////////////////////////////////////
	// 100 MHz core clock
	always #5 clock = ~clock;

	pcs_exec_model pcs_exec_model_i (.clock(clock), .cmd(cmd), .alu(alu));

	pcs_core pcs_core_i (.clock(clock), .rstn(rstn), .bus(bus), .cmd(cmd), .alu(alu), .hw(hw),
		.stack_fault_reset_enable(fault_en), .overflow_clear(ovf_clr), .underflow_clear(unf_clr),
		.pc(pc), .rd_data(rd_data), .rd_valid(rd_valid), .rd_region(rd_region),
		.working_accumulator(wacc), .bank_selector(bsel), .pointer_0(ptr0), .pointer_1(ptr1),
		.interrupt_control(intctl), .status(status), .stack_pointer(sp),
		.stack_overflow_flag(ovf), .stack_underflow_flag(unf), .stack_fault_reset(fault));

	////////////////////////////////////////////////////////////////////////
	// comparison and bus helpers; every task starts and ends at a falling edge
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		bus.wr = 1'b1;
		bus.addr = a;
		bus.wdata = d;
		@(negedge clock);
		bus.wr = 1'b0;
		bus.wdata = ~d;
		// idle cycle: the next call must not raise the strobe in this time step
		@(negedge clock);
	endtask : wr

	// the answer stands for one cycle only, so it is looked at right away
	task automatic rd(input logic [12:0] a, input logic [7:0] e, input pcs_region_t r);
		bus.rd = 1'b1;
		bus.addr = a;
		@(negedge clock);
		bus.rd = 1'b0;
		chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
		chk("rd_data", {8'h00, e}, {8'h00, rd_data});
		chk("rd_region", {13'h0000, r}, {13'h0000, rd_region});
		@(negedge clock);
	endtask : rd

	task automatic op(input pcs_op_t o, input logic [10:0] n);
		pcs_exec_model_i.step(o, n, '0);
	endtask : op

	task automatic st(input logic [14:0] p, input logic [4:0] s);
		chk("pc", {1'b0, p}, {1'b0, pc});
		chk("stack_pointer", {11'h000, s}, {11'h000, sp});
	endtask : st

	task automatic fl(input logic o, input logic u, input logic f);
		chk("flags", {13'h0000, o, u, f}, {13'h0000, ovf, unf, fault});
	endtask : fl

	task automatic summarize;
		if (fails == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (20) @(negedge clock);
		rstn = 1'b1;
		repeat (3) @(negedge clock);
		st(15'h0000, SP_EMPTY);
		chk("status", 16'h0018, {8'h00, status});
		// same core register seen from banks 00, 01, 21 and 3F
		wr(13'h0009, 8'h5A);
		foreach (banks[i]) rd({banks[i], OFF_WACC}, 8'h5A, pcs_reg_core);
		chk("working_accumulator", 16'h005A, {8'h00, wacc});
		// pointer bytes, bank and interrupt control through assorted banks; indirect ports hold nothing
		wr(13'h0004, 8'h11);
		wr(13'h0885, 8'h22);
		wr(13'h1F06, 8'h33);
		wr(13'h0087, 8'h44);
		wr(13'h0108, 8'hFF);
		wr(13'h1E8B, 8'hC1);
		wr(13'h0000, 8'hAA);
		chk("pointer_0", 16'h2211, ptr0);
		chk("pointer_1", 16'h4433, ptr1);
		chk("bank_selector", 16'h003F, {10'h000, bsel});
		chk("interrupt_control", 16'h00C1, {8'h00, intctl});
		rd(13'h0F88, 8'h3F, pcs_reg_core);
		rd(13'h0005, 8'h22, pcs_reg_core);
		rd(13'h0080, 8'h00, pcs_reg_core);
		rd(13'h000C, 8'h00, pcs_reg_sfr);
		rd({6'h3C, 7'h6F}, 8'h00, pcs_reg_sfr);
		rd({6'h3B, 7'h20}, 8'h00, pcs_reg_gpr);
		rd({6'h05, 7'h7F}, 8'h00, pcs_reg_common);
		// low byte write pulls the upper bits from the latch
		wr(13'h000A, 8'h12);
		wr(13'h0102, 8'h34);
		st(15'h1234, SP_EMPTY);
		rd(13'h0002, 8'h34, pcs_reg_core);
		wr(13'h000A, 8'h00);
		wr(13'h0002, 8'h10);
		wr(13'h000A, 8'h08);
		op(pcs_op_call, 11'h123);
		st(15'h0923, 5'h00);
		rd(13'h000A, 8'h08, pcs_reg_core);
		rd(ADR_STACK_TOP_LOW, 8'h11, pcs_reg_stack);
		rd(ADR_STACK_TOP_HIGH, 8'h00, pcs_reg_stack);
		wr(13'h0009, 8'h56);
		op(pcs_op_register_computed_call, 11'h000);
		st(15'h0856, 5'h01);
		rd(ADR_STACK_TOP_LOW, 8'h24, pcs_reg_stack);
		rd(ADR_STACK_TOP_HIGH, 8'h09, pcs_reg_stack);
		op(pcs_op_ret, 11'h000);
		st(15'h0924, 5'h00);
		op(pcs_op_ret, 11'h000);
		st(15'h0011, SP_EMPTY);
		// branches, including a negative offset and a wrap past the top
		wr(13'h0009, 8'hF0);
		op(pcs_op_brw, 11'h000);
		st(15'h0102, SP_EMPTY);
		op(pcs_op_bra, 11'h1FE);
		st(15'h0101, SP_EMPTY);
		op(pcs_op_bra, 11'h0FF);
		st(15'h0201, SP_EMPTY);
		wr(13'h000A, 8'h7F);
		wr(13'h0002, 8'hFF);
		op(pcs_op_inc, 11'h000);
		st(15'h0000, SP_EMPTY);
		wr(13'h0002, 8'hFF);
		op(pcs_op_bra, 11'h001);
		st(15'h0001, SP_EMPTY);
		wr(13'h000A, 8'h00);
		wr(13'h0002, 8'h40);
		op(pcs_op_irq, 11'h000);
		st(15'h0004, 5'h00);
		rd(ADR_STACK_TOP_LOW, 8'h40, pcs_reg_stack);
		op(pcs_op_ret, 11'h000);
		st(15'h0040, SP_EMPTY);
		// reset-status bits only move by hardware, flags of the operation win
		hw = '{1'b1, 1'b0, 1'b1};
		@(negedge clock);
		hw = '0;
		chk("status", 16'h0008, {8'h00, status});
		wr(13'h0003, 8'hFF);
		chk("status", 16'h000F, {8'h00, status});
		fork
			pcs_exec_model_i.step(pcs_op_hold, 11'h000, 7'h74);
			wr(13'h0003, 8'h00);
		join
		chk("status", 16'h000C, {8'h00, status});
		fork
			pcs_exec_model_i.step(pcs_op_hold, 11'h000, 7'h7A);
			wr(13'h0083, 8'hFF);
		join
		chk("status", 16'h0009, {8'h00, status});
		pcs_exec_model_i.step(pcs_op_hold, 11'h000, 7'h78);
		chk("status", 16'h000B, {8'h00, status});
		// only the zero flag is owned, yet the write to all three arithmetic bits is dropped
		fork
			pcs_exec_model_i.step(pcs_op_hold, 11'h000, 7'h40);
			wr(13'h0003, 8'h04);
		join
		chk("status", 16'h000B, {8'h00, status});
		// software positions the top-of-stack pair and edits an entry
		wr(ADR_STACK_POINTER_REG, 8'h03);
		wr(ADR_STACK_TOP_LOW, 8'hAB);
		wr(ADR_STACK_TOP_HIGH, 8'h55);
		rd(ADR_STACK_POINTER_REG, 8'h03, pcs_reg_stack);
		rd(ADR_STACK_TOP_LOW, 8'hAB, pcs_reg_stack);
		op(pcs_op_ret, 11'h000);
		st(15'h55AB, 5'h02);
		wr(ADR_STACK_POINTER_REG, 8'h1F);
		// circular stack: seventeenth push lands on the first entry
		for (int k = 0; k < 16; k++)
			op(pcs_op_call, 11'h100 + 11'(k));
		st(15'h010F, SP_FULL);
		op(pcs_op_call, 11'h200);
		st(15'h0200, 5'h00);
		fl(1'b1, 1'b0, 1'b0);
		rd(ADR_STACK_TOP_LOW, 8'h10, pcs_reg_stack);
		ovf_clr = 1'b1;
		@(negedge clock);
		ovf_clr = 1'b0;
		fl(1'b0, 1'b0, 1'b0);
		op(pcs_op_ret, 11'h000);
		st(15'h0110, SP_EMPTY);
		op(pcs_op_ret, 11'h000);
		st(15'h010F, 5'h0E);
		fl(1'b0, 1'b1, 1'b0);
		unf_clr = 1'b1;
		@(negedge clock);
		unf_clr = 1'b0;
		// fault reset mode: overflow then underflow each restart the counter
		// the fault request stands one cycle, so it is looked at inside the instruction's idle cycle
		fault_en = 1'b1;
		wr(ADR_STACK_POINTER_REG, 8'h0F);
		fork
			op(pcs_op_call, 11'h300);
			begin
				@(negedge clock);
				fl(1'b1, 1'b0, 1'b1);
			end
		join
		st(15'h0000, SP_EMPTY);
		ovf_clr = 1'b1;
		@(negedge clock);
		ovf_clr = 1'b0;
		fl(1'b0, 1'b0, 1'b0);
		fork
			op(pcs_op_ret, 11'h000);
			begin
				@(negedge clock);
				fl(1'b0, 1'b1, 1'b1);
			end
		join
		st(15'h0000, SP_EMPTY);
		summarize();
	end
endmodule : pcs_core_tb
